// *** encoder_feedback_position.sv ***
// encoder feedback unit: quadrature decode, counts, speed, absolute alignment
// assumes encoder and status inputs synchronous to ref_clk_i, apb master outside
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module encoder_feedback_position #(
    parameter int unsigned GATE_LEN = encoder_feedback_pkg::GATE_CYCLES // shorten in simulation
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    output logic irq_o,
    input wire logic chan_a_i,
    input wire logic chan_b_i,
    input wire logic abs_fitted_i,
    input wire logic multiturn_i,
    input wire logic drive_stopped_i,
    input wire logic motor_stopped_i,
    input wire logic abs_link_fault_i,
    input wire logic abs_sample_i,
    input wire logic [17:0] abs_angle_i,
    input wire logic [encoder_feedback_pkg::TURN_BITS-1:0] abs_turns_i,
    output encoder_feedback_pkg::align_state_t absolute_align_state_o,
    output logic position_identify_active_o
);
    import encoder_feedback_pkg::*;

    // gray order 00,01,11,10 mapped to 0..3; difference gives the step
    function automatic logic [1:0] quad_step(input logic [1:0] prev, input logic [1:0] cur);
        logic [1:0] bp;
        logic [1:0] bc;
        bp = {prev[1], prev[1] ^ prev[0]};
        bc = {cur[1], cur[1] ^ cur[0]};
        return bc - bp;
    endfunction

    // state to wait in before an attempt may begin
    function automatic align_state_t pre_state(input logic abs_on, input logic drv,
                                               input logic mot, input logic flt);
        if (!abs_on) return ALIGN_NOT_REQUIRED;
        else if (!drv) return ALIGN_DRIVE_RUNNING;
        else if (!mot) return ALIGN_MOTOR_RUNNING;
        else if (flt) return ALIGN_LINK_FAULT;
        else return ALIGN_CALIBRATING;
    endfunction

    // quadrature and counters
    logic [1:0] ab_ff, nxt_ab; // last sampled channel pair
    logic [31:0] edge_ff, nxt_edge; // signed edge count
    logic [17:0] pos_ff, nxt_pos; // edge position within one turn
    logic [31:0] rev_ff, nxt_rev; // revolution count
    logic dir_ff, nxt_dir; // high while turning backward
    logic [31:0] win_ff, nxt_win; // signed edges in the current window
    logic [31:0] gate_ff, nxt_gate; // window cycle counter
    logic [1:0] step; // decoded step this cycle
    logic [17:0] lim; // edges per turn
    logic tick; // window ends this cycle

    // serial divider for speed
    logic busy_ff, nxt_busy; // division in progress
    logic pass_ff, nxt_pass; // 0 hertz pass, 1 rpm pass
    logic [5:0] cnt_ff, nxt_cnt; // bits still to produce
    logic [31:0] num_ff, nxt_num; // dividend shifting into quotient
    logic [31:0] rem_ff, nxt_rem; // partial remainder
    logic [31:0] den_ff, nxt_den; // divisor
    logic [31:0] mag_ff, nxt_mag; // window magnitude, kept for the second pass
    logic [31:0] freq_ff, nxt_freq; // rotation_frequency
    logic [31:0] rpm_ff, nxt_rpm; // shaft rpm
    logic [31:0] rem_sh; // remainder after the shift

    // alignment
    align_state_t st_ff, nxt_st;
    logic [3:0] att_ff, nxt_att; // failed attempts so far
    logic go_ff, nxt_go; // one-cycle restart request
    logic idact_ff, nxt_idact; // identify phase flag, registered so the pin comes from a flop
    logic cal_load; // load absolute position into counters
    logic retry_clr; // alignment carried out
    logic [2:0] ev; // event pulses

    // registers and bus
    logic retry_ff, nxt_retry; // retry request
    logic [15:0] lines_ff, nxt_lines; // lines per turn
    logic [2:0] irq_st_ff, nxt_irq_st; // sticky events
    logic [2:0] irq_mask_ff, nxt_irq_mask; // event enables
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic irq_ff, nxt_irq;
    logic wr; // write takes effect this edge

    assign step = quad_step(ab_ff, {chan_a_i, chan_b_i});
    assign lim = {lines_ff, 2'b00};
    assign tick = (gate_ff == GATE_LEN - 1);
    assign wr = psel_i && penable_i && pwrite_i && pready_ff;

    // decode steps and keep edge, position and turn counts
    always_comb begin
        nxt_ab = {chan_a_i, chan_b_i};
        nxt_edge = edge_ff;
        nxt_pos = pos_ff;
        nxt_rev = rev_ff;
        nxt_dir = dir_ff;
        nxt_gate = tick ? 32'h0 : gate_ff + 32'h1;
        nxt_win = tick ? 32'h0 : win_ff; // window restarts so no edge is counted twice
        if (step == STEP_UP) begin
            nxt_edge = edge_ff + 32'h1;
            nxt_win = nxt_win + 32'h1;
            nxt_dir = 1'b0;
            if (lim != 18'h0 && pos_ff == lim - 18'h1) begin
                nxt_pos = 18'h0;
                nxt_rev = rev_ff + 32'h1;
            end else begin
                nxt_pos = pos_ff + 18'h1;
            end
        end else if (step == STEP_DOWN) begin
            nxt_edge = edge_ff - 32'h1;
            nxt_win = nxt_win - 32'h1;
            nxt_dir = 1'b1;
            if (pos_ff == 18'h0) begin
                nxt_pos = (lim == 18'h0) ? 18'h0 : lim - 18'h1;
                nxt_rev = rev_ff - 32'h1;
            end else begin
                nxt_pos = pos_ff - 18'h1;
            end
        end
        // a double change carries no direction, so it is dropped
        if (cal_load) begin
            nxt_pos = abs_angle_i;
            if (multiturn_i) begin
                nxt_rev = {rev_ff[31:TURN_BITS], abs_turns_i};
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ab_ff <= 2'h0;
            edge_ff <= 32'h0;
            pos_ff <= 18'h0;
            rev_ff <= 32'h0;
            dir_ff <= 1'b0;
            win_ff <= 32'h0;
            gate_ff <= 32'h0;
        end else begin
            ab_ff <= nxt_ab;
            edge_ff <= nxt_edge;
            pos_ff <= nxt_pos;
            rev_ff <= nxt_rev;
            dir_ff <= nxt_dir;
            win_ff <= nxt_win;
            gate_ff <= nxt_gate;
        end
    end

    // two divisions per window: edges over lines*4, then edges*15 over lines
    // one bit a cycle keeps the area small; frequency lags the window by 32 cycles, rpm by 64
    always_comb begin
        nxt_busy = busy_ff;
        nxt_pass = pass_ff;
        nxt_cnt = cnt_ff;
        nxt_num = num_ff;
        nxt_rem = rem_ff;
        nxt_den = den_ff;
        nxt_mag = mag_ff;
        nxt_freq = freq_ff;
        nxt_rpm = rpm_ff;
        rem_sh = {rem_ff[30:0], num_ff[31]};
        if (tick) begin
            nxt_mag = win_ff[31] ? 32'h0 - win_ff : win_ff;
            nxt_num = nxt_mag;
            nxt_den = {14'h0, lim};
            nxt_rem = 32'h0;
            nxt_cnt = 6'd32;
            nxt_pass = 1'b0;
            nxt_busy = (lim != 18'h0);
            if (lim == 18'h0) begin // no lines set: speed reads zero
                nxt_freq = 32'h0;
                nxt_rpm = 32'h0;
            end
        end else if (busy_ff) begin
            if (rem_sh >= den_ff) begin
                nxt_rem = rem_sh - den_ff;
                nxt_num = {num_ff[30:0], 1'b1};
            end else begin
                nxt_rem = rem_sh;
                nxt_num = {num_ff[30:0], 1'b0};
            end
            nxt_cnt = cnt_ff - 6'd1;
            if (cnt_ff == 6'd1 && !pass_ff) begin
                nxt_freq = nxt_num;
                nxt_num = 32'(mag_ff * (SEC_PER_MIN / EDGES_PER_LINE));
                nxt_den = {16'h0, lines_ff};
                nxt_rem = 32'h0;
                nxt_cnt = 6'd32;
                nxt_pass = 1'b1;
            end else if (cnt_ff == 6'd1) begin
                nxt_rpm = nxt_num;
                nxt_busy = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_ff <= 1'b0;
            pass_ff <= 1'b0;
            cnt_ff <= 6'd0;
            num_ff <= 32'h0;
            rem_ff <= 32'h0;
            den_ff <= 32'h0;
            mag_ff <= 32'h0;
            freq_ff <= 32'h0;
            rpm_ff <= 32'h0;
        end else begin
            busy_ff <= nxt_busy;
            pass_ff <= nxt_pass;
            cnt_ff <= nxt_cnt;
            num_ff <= nxt_num;
            rem_ff <= nxt_rem;
            den_ff <= nxt_den;
            mag_ff <= nxt_mag;
            freq_ff <= nxt_freq;
            rpm_ff <= nxt_rpm;
        end
    end

    // alignment sequence: wait for standstill, load absolute, confirm with a second sample
    always_comb begin
        nxt_st = st_ff;
        nxt_att = att_ff;
        cal_load = 1'b0;
        retry_clr = 1'b0;
        ev = 3'h0;
        if (go_ff) begin
            nxt_att = 4'h0;
            nxt_st = pre_state(abs_fitted_i, drive_stopped_i, motor_stopped_i,
                               abs_link_fault_i);
            retry_clr = !abs_fitted_i;
        end else begin
            unique case (st_ff)
                ALIGN_NOT_REQUIRED, ALIGN_LOST, ALIGN_FAILED: begin
                    nxt_st = st_ff; // held until a restart
                end
                ALIGN_DRIVE_RUNNING, ALIGN_MOTOR_RUNNING, ALIGN_LINK_FAULT: begin
                    nxt_st = pre_state(abs_fitted_i, drive_stopped_i, motor_stopped_i,
                                       abs_link_fault_i);
                end
                ALIGN_CALIBRATING: begin
                    if (abs_link_fault_i) begin
                        nxt_st = ALIGN_LINK_FAULT;
                    end else if (abs_sample_i) begin
                        cal_load = 1'b1;
                        nxt_st = ALIGN_IDENTIFY;
                    end
                end
                ALIGN_IDENTIFY: begin
                    if (abs_link_fault_i) begin
                        nxt_st = ALIGN_LINK_FAULT;
                    end else if (abs_sample_i) begin
                        if ((abs_angle_i - pos_ff) <= MATCH_TOL
                            || (pos_ff - abs_angle_i) <= MATCH_TOL) begin
                            nxt_st = ALIGN_COMPLETED;
                            retry_clr = 1'b1;
                            ev[EV_DONE] = 1'b1;
                        end else if (att_ff + 4'h1 >= MAX_ATTEMPTS) begin
                            nxt_att = att_ff + 4'h1;
                            nxt_st = ALIGN_FAILED;
                            retry_clr = 1'b1;
                            ev[EV_FAILED] = 1'b1;
                        end else begin
                            nxt_att = att_ff + 4'h1;
                            nxt_st = ALIGN_CALIBRATING;
                        end
                    end
                end
                ALIGN_COMPLETED: begin
                    if (abs_link_fault_i) begin
                        nxt_st = ALIGN_LOST;
                        ev[EV_LOST] = 1'b1;
                    end
                end
            endcase
        end
        nxt_idact = (nxt_st == ALIGN_IDENTIFY);
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_ff <= ALIGN_NOT_REQUIRED;
            att_ff <= 4'h0;
            go_ff <= 1'b1; // power-up start
            idact_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            att_ff <= nxt_att;
            go_ff <= nxt_go;
            idact_ff <= nxt_idact;
        end
    end

    // apb slave: setup cycle prepares the answer, access phase lasts one cycle
    always_comb begin
        nxt_pready = psel_i && !penable_i;
        nxt_prdata = 32'h0;
        nxt_pslverr = 1'b0;
        nxt_retry = retry_clr ? 1'b0 : retry_ff;
        nxt_lines = lines_ff;
        nxt_irq_mask = irq_mask_ff;
        nxt_irq_st = irq_st_ff;
        nxt_go = 1'b0;
        if (psel_i && !penable_i) begin
            unique case (paddr_i)
                ADDR_CTRL: nxt_prdata = {31'h0, retry_ff};
                ADDR_LINES: nxt_prdata = {16'h0, lines_ff};
                ADDR_EDGES: nxt_prdata = edge_ff;
                ADDR_REVS: nxt_prdata = rev_ff;
                ADDR_FREQ: nxt_prdata = freq_ff;
                ADDR_RPM: nxt_prdata = rpm_ff;
                ADDR_STATUS: nxt_prdata = {20'h0, att_ff, 2'h0, st_ff == ALIGN_IDENTIFY,
                                           dir_ff, st_ff};
                ADDR_IRQ_ST: nxt_prdata = {29'h0, irq_st_ff};
                ADDR_IRQ_MASK: nxt_prdata = {29'h0, irq_mask_ff};
                default: nxt_pslverr = 1'b1; // unmapped address
            endcase
        end
        if (wr) begin
            unique case (paddr_i)
                ADDR_CTRL: begin
                    if (pwdata_i[0]) begin // set wins over the self-clear
                        nxt_retry = 1'b1;
                        nxt_go = 1'b1;
                    end
                end
                ADDR_LINES: begin
                    nxt_lines = pwdata_i[15:0];
                    nxt_go = 1'b1; // setting change restarts
                end
                ADDR_IRQ_ST: nxt_irq_st = irq_st_ff & ~pwdata_i[2:0];
                ADDR_IRQ_MASK: nxt_irq_mask = pwdata_i[2:0];
                default: nxt_irq_st = irq_st_ff; // read-only or unmapped
            endcase
        end
        nxt_irq_st = nxt_irq_st | ev; // a new event beats a clear
        nxt_irq = |(nxt_irq_st & nxt_irq_mask);
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            retry_ff <= 1'b0;
            lines_ff <= LINES_RST;
            irq_st_ff <= 3'h0;
            irq_mask_ff <= IRQ_MASK_RST;
            prdata_ff <= 32'h0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            retry_ff <= nxt_retry;
            lines_ff <= nxt_lines;
            irq_st_ff <= nxt_irq_st;
            irq_mask_ff <= nxt_irq_mask;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            irq_ff <= nxt_irq;
        end
    end

    assign prdata_o = prdata_ff;
    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;
    assign irq_o = irq_ff;
    assign absolute_align_state_o = st_ff;
    assign position_identify_active_o = idact_ff;

    // checks of the decode, counters, rpm result and alignment sequence
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    sequence s_fwd;
        step == STEP_UP && !cal_load;
    endsequence
    sequence s_done;
        st_ff == ALIGN_IDENTIFY ##1 st_ff == ALIGN_COMPLETED;
    endsequence

    chk_quad_up: assert property (s_fwd |=> edge_ff == $past(edge_ff) + 32'h1 && !dir_ff)
        else $error("forward edge not counted");
    chk_quad_down: assert property (step == STEP_DOWN |=> edge_ff == $past(edge_ff) - 32'h1)
        else $error("reverse edge not subtracted");
    chk_quad_double: assert property (step == STEP_DOUBLE |=> $stable(edge_ff))
        else $error("double change altered the count");
    chk_rev_load: assert property (cal_load && multiturn_i
        |=> rev_ff[TURN_BITS-1:0] == $past(abs_turns_i))
        else $error("turn bits not loaded");
    chk_rev_hold: assert property (!cal_load && step == STEP_NONE |=> $stable(rev_ff))
        else $error("revolution count moved without an edge");
    chk_not_required: assert property (go_ff && !abs_fitted_i
        |=> st_ff == ALIGN_NOT_REQUIRED [*2])
        else $error("non-absolute encoder not reported");
    chk_fail_sticky: assert property (st_ff == ALIGN_FAILED && !go_ff
        |=> st_ff == ALIGN_FAILED)
        else $error("failed state left without restart");
    chk_retry_clear: assert property (s_done ##0 !$past(wr) |-> !retry_ff)
        else $error("retry request not cleared");
    chk_restart_ok: assert property (go_ff && abs_fitted_i && drive_stopped_i && motor_stopped_i
        && !abs_link_fault_i |=> st_ff == ALIGN_CALIBRATING)
        else $error("alignment not started");
    chk_speed_calc: assert property (busy_ff && pass_ff && cnt_ff == 6'd1 && !tick
        |=> rpm_ff == $past(mag_ff) * 32'd15 / $past(den_ff))
        else $error("rpm result wrong");
endmodule

// *** encoder_feedback_pkg.sv ***
// constants, register map and state type of the encoder feedback unit
// assumes a single 100 MHz clock and a 32-bit apb register bus
package encoder_feedback_pkg;

    // clock rate and the speed measurement window
    localparam int unsigned CLK_HZ = 100_000_000; // ref_clk_i rate
    localparam int unsigned GATE_TIME_MS = 1000; // one second window
    localparam int unsigned GATE_CYCLES = CLK_HZ / 1000 * GATE_TIME_MS; // cycles per window

    // quadrature decode
    localparam int unsigned EDGES_PER_LINE = 4; // every edge of both channels
    localparam int unsigned SEC_PER_MIN = 60; // hz to rpm
    localparam logic [1:0] STEP_NONE = 2'h0; // no movement
    localparam logic [1:0] STEP_UP = 2'h1; // one edge forward
    localparam logic [1:0] STEP_DOUBLE = 2'h2; // both channels changed
    localparam logic [1:0] STEP_DOWN = 2'h3; // one edge backward

    // absolute alignment
    localparam int unsigned TURN_BITS = 12; // turn field of the absolute encoder
    localparam logic [3:0] MAX_ATTEMPTS = 4'h3; // tries before giving up
    localparam logic [17:0] MATCH_TOL = 18'h00004; // allowed position mismatch

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00; // bit0 retry request
    localparam logic [7:0] ADDR_LINES = 8'h04; // encoder lines per turn
    localparam logic [7:0] ADDR_EDGES = 8'h08; // signed edge count
    localparam logic [7:0] ADDR_REVS = 8'h0c; // revolution count
    localparam logic [7:0] ADDR_FREQ = 8'h10; // rotation_frequency, hz
    localparam logic [7:0] ADDR_RPM = 8'h14; // shaft speed, rpm
    localparam logic [7:0] ADDR_STATUS = 8'h18; // state, direction, attempts
    localparam logic [7:0] ADDR_IRQ_ST = 8'h1c; // sticky events, write one to clear
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h20; // event enables

    // reset values
    localparam logic [15:0] LINES_RST = 16'h0400; // lines per turn after reset
    localparam logic [2:0] IRQ_MASK_RST = 3'h0; // all events masked

    // event bit positions in status and mask
    localparam int unsigned EV_DONE = 0; // alignment completed
    localparam int unsigned EV_FAILED = 1; // alignment failed
    localparam int unsigned EV_LOST = 2; // alignment lost

    // alignment state, listed in the order of its reported code
    typedef enum logic [3:0] {
        ALIGN_NOT_REQUIRED,
        ALIGN_DRIVE_RUNNING,
        ALIGN_MOTOR_RUNNING,
        ALIGN_LINK_FAULT,
        ALIGN_CALIBRATING,
        ALIGN_IDENTIFY,
        ALIGN_COMPLETED,
        ALIGN_LOST,
        ALIGN_FAILED
    } align_state_t;

endpackage

// *** shaft_encoder_model.sv ***
// shaft encoder model: quadrature channels and absolute samples
// assumes the bench pulses step and sample requests for one cycle
`timescale 1ns/1ps
module shaft_encoder_model (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic step_i, // move one edge
    input wire logic rev_i, // step backwards
    input wire logic dbl_i, // flip both channels at once
    input wire logic smp_i, // send an absolute sample
    input wire logic [17:0] skew_i, // error added to the sample
    input wire logic [11:0] turns_i, // multiturn count to report
    output logic chan_a_o,
    output logic chan_b_o,
    output logic abs_sample_o,
    output logic [17:0] abs_angle_o,
    output logic [11:0] abs_turns_o
);
    logic [1:0] ph_ff; // quadrature phase
    logic [17:0] pos_ff; // shaft position in edges
    // gray order 00,01,11,10: channels a quarter cycle apart
    assign chan_a_o = ph_ff[1];
    assign chan_b_o = ph_ff[1] ^ ph_ff[0];
    // outputs change just after the edge, like the real encoder
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ph_ff <= 2'h0;
            pos_ff <= 18'h0;
            abs_sample_o <= 1'b0;
            abs_angle_o <= 18'h0;
            abs_turns_o <= 12'h0;
        end else begin
            if (step_i) begin
                // a double change moves the phase by two, a fault on the wire
                ph_ff <= dbl_i ? ph_ff + 2'h2 : (rev_i ? ph_ff - 2'h1 : ph_ff + 2'h1);
                pos_ff <= dbl_i ? pos_ff : (rev_i ? pos_ff - 18'h1 : pos_ff + 18'h1);
            end
            abs_sample_o <= smp_i;
            // outside a sample the words are invalid, so show their inverse
            abs_angle_o <= smp_i ? pos_ff + skew_i : ~abs_angle_o;
            abs_turns_o <= smp_i ? turns_i : ~abs_turns_o;
        end
    end
endmodule

// *** testbench.sv ***
// self-checking bench for the encoder feedback unit
// assumes the encoder model beside it and a 200-cycle speed window
`timescale 1ns/1ps
module testbench;
    import encoder_feedback_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] d; logic e;} row_t;
    logic ref_clk_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0, err;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, irq, cha, chb, smp_o, idact, fit = 0, mt = 1;
    logic drv = 1, mot = 1, flt = 0, step = 0, rev = 0, dbl = 0, smp = 0;
    logic [17:0] ang, skew = 18'h0;
    logic [11:0] turns, tn = 12'h005; // turn count the encoder reports
    align_state_t st;
    int err_total = 0, checks = 0, cyc = 0;
    // reset values of every register except ADDR_FREQ and ADDR_RPM, plus one unmapped word
    row_t rows[8] = '{'{ADDR_CTRL, 32'h0, 1'b0}, '{ADDR_LINES, {16'h0, LINES_RST}, 1'b0},
        '{ADDR_EDGES, 32'h0, 1'b0}, '{ADDR_REVS, 32'h0, 1'b0}, '{ADDR_STATUS, 32'h0, 1'b0},
        '{ADDR_IRQ_ST, 32'h0, 1'b0}, '{ADDR_IRQ_MASK, 32'h0, 1'b0}, '{8'h24, 32'h0, 1'b1}};
    // {drive stopped, motor stopped, link fault} and the state they give
    logic [6:0] pre[4] = '{{3'b010, 4'h1}, {3'b100, 4'h2}, {3'b111, 4'h3}, {3'b110, 4'h4}};
    always #5 ref_clk_i = ~ref_clk_i;
    encoder_feedback_position #(.GATE_LEN(200)) dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .irq_o(irq), .chan_a_i(cha), .chan_b_i(chb), .abs_fitted_i(fit), .multiturn_i(mt),
        .drive_stopped_i(drv), .motor_stopped_i(mot), .abs_link_fault_i(flt),
        .abs_sample_i(smp_o), .abs_angle_i(ang), .abs_turns_i(turns),
        .absolute_align_state_o(st), .position_identify_active_o(idact));
    shaft_encoder_model enc (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .step_i(step),
        .rev_i(rev), .dbl_i(dbl), .smp_i(smp), .skew_i(skew), .turns_i(tn),
        .chan_a_o(cha), .chan_b_o(chb), .abs_sample_o(smp_o), .abs_angle_o(ang),
        .abs_turns_o(turns));
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one apb transfer; an idle edge first keeps drivers from double assignment
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge ref_clk_i);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        if (pready !== 1'b1) err_total++;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), q & m, e);
    endtask
    task automatic move(input logic r, input logic d, input int n, input int gap);
        repeat (n) begin
            @(posedge ref_clk_i);
            {step, rev, dbl} <= {1'b1, r, d};
            @(posedge ref_clk_i);
            step <= 1'b0;
            repeat (gap) @(posedge ref_clk_i);
        end
    endtask
    task automatic sample(input logic [17:0] s);
        @(posedge ref_clk_i);
        {smp, skew} <= {1'b1, s};
        @(posedge ref_clk_i);
        smp <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
    endtask
    task automatic st_is(input logic [3:0] e);
        chk("state", {28'h0, st}, {28'h0, e});
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // a hang counts as a mismatch
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (4) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            apb(1'b0, rows[i].a, 32'h0);
            chk($sformatf("reg %h", rows[i].a), q, rows[i].d);
            chk("slverr", {31'h0, err}, {31'h0, rows[i].e});
        end
        st_is(4'h0);
        move(1'b0, 1'b0, 5, 2);
        rd(ADDR_EDGES, '1, 32'h5);
        rd(ADDR_STATUS, 32'h10, 32'h0);
        move(1'b1, 1'b0, 2, 2);
        rd(ADDR_EDGES, '1, 32'h3);
        rd(ADDR_STATUS, 32'h10, 32'h10);
        move(1'b0, 1'b1, 1, 2);
        rd(ADDR_EDGES, '1, 32'h3);
        // one edge per 10 cycles: 20 edges per window, one line per turn
        apb(1'b1, ADDR_LINES, 32'h1);
        fork
            move(1'b0, 1'b0, 80, 8);
            begin
                repeat (700) @(posedge ref_clk_i);
                rd(ADDR_FREQ, '1, 32'h5);
                rd(ADDR_RPM, '1, 32'd300);
            end
        join
        fit <= 1'b1;
        // the last row starts through a settings change instead of a retry
        foreach (pre[i]) begin
            {drv, mot, flt} <= pre[i][6:4];
            apb(1'b1, i == 3 ? ADDR_LINES : ADDR_CTRL, i == 3 ? 32'h400 : 32'h1);
            repeat (3) @(posedge ref_clk_i);
            st_is(pre[i][3:0]);
        end
        rd(ADDR_CTRL, 32'h1, 32'h1);
        sample(18'h0);
        st_is(4'h5);
        chk("identify", {31'h0, idact}, 32'h1);
        sample(18'h0);
        st_is(4'h6);
        rd(ADDR_CTRL, 32'h1, 32'h0);
        rd(ADDR_REVS, 32'hfff, 32'h5);
        rd(ADDR_IRQ_ST, 32'h7, 32'h1);
        chk("irq masked", {31'h0, irq}, 32'h0);
        apb(1'b1, ADDR_IRQ_MASK, 32'h7);
        repeat (2) @(posedge ref_clk_i);
        chk("irq raised", {31'h0, irq}, 32'h1);
        apb(1'b1, ADDR_IRQ_ST, 32'h1);
        repeat (2) @(posedge ref_clk_i);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        flt <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        st_is(4'h7);
        flt <= 1'b0;
        apb(1'b1, ADDR_CTRL, 32'h1);
        repeat (3) @(posedge ref_clk_i);
        st_is(4'h4);
        // every attempt loads, then sees a sample 100 counts off
        repeat (3) begin
            sample(18'h0);
            sample(18'h64);
        end
        st_is(4'h8);
        rd(ADDR_CTRL, 32'h1, 32'h0);
        rd(ADDR_STATUS, 32'hf2f, 32'h308);
        rd(ADDR_IRQ_ST, 32'h7, 32'h6);
        repeat (50) @(posedge ref_clk_i);
        st_is(4'h8);
        apb(1'b1, ADDR_CTRL, 32'h1);
        repeat (3) @(posedge ref_clk_i);
        st_is(4'h4);
        // without multiturn the load keeps the counted turns
        {mt, tn} <= {1'b0, 12'h00a};
        sample(18'h0);
        st_is(4'h5);
        rd(ADDR_REVS, 32'hfff, 32'h5);
        tally_and_finish();
    end
endmodule
